// ---- csr_pkg.sv ----
// Constants, carriers and state layout for the core status/option bank.
// Assumes one clock domain; the core presents one request per cycle.
package csr_pkg;
    // Byte offsets on the register bus
    localparam logic [11:0] CSR_OFF_STATUS = 12'h000;
    localparam logic [11:0] CSR_OFF_OPTION = 12'h004;
    localparam logic [11:0] CSR_OFF_PULLUP = 12'h008;
    localparam logic [11:0] CSR_OFF_TICK   = 12'h00C;
    // Status field positions
    localparam int CSR_ST_C   = 0;
    localparam int CSR_ST_DC  = 1;
    localparam int CSR_ST_Z   = 2;
    localparam int CSR_ST_PD  = 3;
    localparam int CSR_ST_TO  = 4;
    localparam int CSR_ST_RP0 = 5;
    localparam int CSR_ST_RP1 = 6;
    localparam int CSR_ST_IRP = 7;
    // Option field positions
    localparam int CSR_OP_PS0   = 0;
    localparam int CSR_OP_PS2   = 2;
    localparam int CSR_OP_OWNER = 3;
    localparam int CSR_OP_TEDGE = 4;
    localparam int CSR_OP_TSRC  = 5;
    localparam int CSR_OP_IEDGE = 6;
    localparam int CSR_OP_PUDIS = 7;
    // Reset values and the select code for an unmapped address
    localparam logic [7:0] CSR_STATUS_RST = 8'h18;
    localparam logic [7:0] CSR_OPTION_RST = 8'hFF;
    localparam logic [7:0] CSR_PULLUP_RST = 8'h00;
    localparam logic [7:0] CSR_TICK_RST   = 8'h00;
    localparam logic [2:0] CSR_SEL_NONE   = 3'h7;

    typedef enum logic [3:0] {
        CSR_NONE, CSR_ADD, CSR_SUB, CSR_AND, CSR_IOR, CSR_XOR,
        CSR_ROTL, CSR_ROTR, CSR_MOVE, CSR_CLEAR
    } csr_op_type;

    typedef struct packed {
        csr_op_type op;
        logic [7:0] acc;
        logic [7:0] file;
        logic       dest_status;
        logic       dest_option;
        logic [6:0] dir_addr;
        logic [7:0] fsr;
    } csr_core_req_type;

    typedef struct packed {
        logic [7:0] res;
        logic       z;
        logic       dc;
        logic       c;
        logic       z_upd;
        logic       dc_upd;
        logic       c_upd;
    } csr_alu_type;

    typedef struct packed {
        logic [7:0]  status;
        logic [7:0]  option;
        logic [7:0]  pullup_mask;
        logic [7:0]  tick_count;
        logic [7:0]  prescale;
        logic        ext_s1;
        logic        ext_s2;
        logic        ext_p;
        logic        tck_s1;
        logic        tck_s2;
        logic        tck_p;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        logic [7:0]  alu_result;
        logic [8:0]  dir_addr;
        logic [8:0]  ind_addr;
        logic [7:0]  pullup_en;
        logic        ext_irq;
        logic        tick_ovf;
        logic        wdt_tick;
    } csr_state_type;

    localparam csr_state_type CSR_STATE_RST = '{
        status: CSR_STATUS_RST, option: CSR_OPTION_RST,
        pullup_mask: CSR_PULLUP_RST, tick_count: CSR_TICK_RST,
        default: '0
    };
endpackage

// ---- csr_core_status_option_regs.sv ----
// Core status and option registers with flag logic, bank select,
// pull-up gating, external edge select and shared prescaler.
// Assumes APB master on pclk; core strobes are pclk-synchronous pulses.
//
// The APB interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
// Behaviour
// RULE1: Flag-writing ops keep computed Z, DC, C
// RULE2: Expiry and power-down flags ignore writes
// RULE3: File clear zeroes banks, sets Z
// RULE4: Software alters status with flagless ops
// RULE5: Subtraction carries mean inverted borrow
// RULE6: Indirect bank bit picks upper half
// RULE7: Direct bank bits pick one of four
// RULE8: Expiry flag set on reset, kick, sleep
// RULE9: Watchdog timeout clears expiry flag
// RULE10: Power-down set on reset, kick; sleep clears
// RULE11: Zero flag marks zero result
// RULE12: Digit carry from low nibble
// RULE13: Carry from top bit
// RULE14: Subtract via complement; rotates load carry
// RULE15: Option fully read/write, resets to ones
// RULE16: Pull-up disable overrides mask bits
// RULE17: Edge bit picks external interrupt edge
// RULE18: Source bit picks pin or cycle clock
// RULE19: Edge bit picks pin transition direction
// RULE20: Owner bit gives prescaler to watchdog
// RULE21: Ratio field doubles divide per step
module csr_core_status_option_regs (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [11:0]               paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire csr_pkg::csr_core_req_type core_req,
    input  wire logic                      watchdog_kick_op,
    input  wire logic                      sleep_op,
    input  wire logic                      watchdog_timeout,
    input  wire logic                      instr_cycle,
    input  wire logic                      wdt_base_tick,
    input  wire logic                      ext_irq_pin,
    input  wire logic                      tick_input_pin,
    output logic      [7:0]                status_flags,
    output logic      [7:0]                option_bits,
    output logic      [7:0]                alu_result,
    output logic      [8:0]                dir_addr,
    output logic      [8:0]                ind_addr,
    output logic      [7:0]                pullup_en,
    output logic                           ext_irq_event,
    output logic                           tick_overflow,
    output logic                           wdt_tick
);
    csr_pkg::csr_state_type q;
    csr_pkg::csr_state_type d;
    csr_pkg::csr_alu_type   alu;
    logic [2:0] sel;
    logic       src_ev;
    logic       tick_inc;
    logic [3:0] ps;

    // Register select from byte address
    function automatic logic [2:0] csr_sel(input logic [11:0] a);
        unique case (a)
            csr_pkg::CSR_OFF_STATUS: csr_sel = 3'h0;
            csr_pkg::CSR_OFF_OPTION: csr_sel = 3'h1;
            csr_pkg::CSR_OFF_PULLUP: csr_sel = 3'h2;
            csr_pkg::CSR_OFF_TICK:   csr_sel = 3'h3;
            default:                 csr_sel = csr_pkg::CSR_SEL_NONE;
        endcase
    endfunction

    // Low n bits set, n in 0..8
    function automatic logic [7:0] csr_mask(input logic [3:0] n);
        csr_mask = 8'hFF >> (4'h8 - n);
    endfunction

    function automatic csr_pkg::csr_alu_type csr_alu(
        input csr_pkg::csr_core_req_type r,
        input logic                      cin
    );
        logic [8:0] sum;
        logic [4:0] nib;
        csr_pkg::csr_alu_type o;
        sum = 9'h000;
        nib = 5'h00;
        o   = '0;
        unique case (r.op)
            csr_pkg::CSR_ADD: begin
                sum = {1'b0, r.file} + {1'b0, r.acc};
                nib = {1'b0, r.file[3:0]} + {1'b0, r.acc[3:0]};
            end
            csr_pkg::CSR_SUB: begin
                // File minus accumulator as add of complement
                sum = {1'b0, r.file} + {1'b0, ~r.acc} + 9'h001; // RULE14
                nib = {1'b0, r.file[3:0]} + {1'b0, ~r.acc[3:0]} + 5'h01;
            end
            default: begin
                sum = 9'h000;
                nib = 5'h00;
            end
        endcase
        unique case (r.op)
            csr_pkg::CSR_ADD, csr_pkg::CSR_SUB: begin
                o.res    = sum[7:0];
                o.c      = sum[8]; // RULE13 RULE5
                o.dc     = nib[4]; // RULE12
                o.c_upd  = 1'b1;
                o.dc_upd = 1'b1;
                o.z_upd  = 1'b1;
            end
            csr_pkg::CSR_AND: begin
                o.res   = r.acc & r.file;
                o.z_upd = 1'b1;
            end
            csr_pkg::CSR_IOR: begin
                o.res   = r.acc | r.file;
                o.z_upd = 1'b1;
            end
            csr_pkg::CSR_XOR: begin
                o.res   = r.acc ^ r.file;
                o.z_upd = 1'b1;
            end
            csr_pkg::CSR_ROTL: begin
                o.res   = {r.file[6:0], cin};
                o.c     = r.file[7]; // RULE14
                o.c_upd = 1'b1;
            end
            csr_pkg::CSR_ROTR: begin
                o.res   = {cin, r.file[7:1]};
                o.c     = r.file[0]; // RULE14
                o.c_upd = 1'b1;
            end
            csr_pkg::CSR_CLEAR: begin
                o.res   = 8'h00;
                o.z_upd = 1'b1;
            end
            csr_pkg::CSR_MOVE: o.res = r.acc;
            csr_pkg::CSR_NONE: o.res = 8'h00;
            default:           o.res = 8'h00;
        endcase
        o.z = (o.res == 8'h00); // RULE11
        return o;
    endfunction

    assign alu = csr_alu(core_req, q.status[csr_pkg::CSR_ST_C]);
    assign sel = csr_sel(paddr);
    assign ps  = {1'b0, q.option[csr_pkg::CSR_OP_PS2:csr_pkg::CSR_OP_PS0]};

    // Tick event source; pin path is already synchronised
    always_comb begin
        if (q.option[csr_pkg::CSR_OP_TSRC]) begin // RULE18
            if (q.option[csr_pkg::CSR_OP_TEDGE]) begin // RULE19
                src_ev = q.tck_p & ~q.tck_s2;
            end else begin
                src_ev = ~q.tck_p & q.tck_s2;
            end
        end else begin
            src_ev = instr_cycle;
        end
        if (q.option[csr_pkg::CSR_OP_OWNER]) begin // RULE20
            tick_inc = src_ev;
        end else begin
            // Divide by two to the power ps+1
            tick_inc = src_ev && ((q.prescale & csr_mask(ps + 4'h1)) == csr_mask(ps + 4'h1)); // RULE21
        end
    end

    always_comb begin
        d = q;
        d.alu_result = alu.res;
        // Setup cycle arms pready, so every access takes one wait-free cycle
        d.pready = psel & ~penable;
        if (psel && !penable) begin
            d.pslverr = (sel == csr_pkg::CSR_SEL_NONE);
            unique case (sel)
                3'h0:    d.prdata = {24'h000000, q.status};
                3'h1:    d.prdata = {24'h000000, q.option};
                3'h2:    d.prdata = {24'h000000, q.pullup_mask};
                3'h3:    d.prdata = {24'h000000, q.tick_count};
                default: d.prdata = 32'h00000000;
            endcase
        end
        if (psel && penable && q.pready && pwrite) begin
            unique case (sel)
                3'h0: d.status = {pwdata[7:5], q.status[4:3], pwdata[2:0]}; // RULE2
                3'h1: d.option = pwdata[7:0]; // RULE15
                3'h2: d.pullup_mask = pwdata[7:0];
                3'h3: d.tick_count = pwdata[7:0];
                default: d.pslverr = q.pslverr;
            endcase
        end
        // Core write beats a bus write in the same cycle
        if (core_req.op != csr_pkg::CSR_NONE) begin
            if (core_req.dest_option) begin
                d.option = alu.res;
            end
            if (core_req.dest_status) begin
                // Any flag-affecting op blocks the write of all three flags
                d.status = {alu.res[7:5], q.status[4:3],
                            (alu.z_upd || alu.dc_upd || alu.c_upd) ? q.status[2:0] : alu.res[2:0]}; // RULE1 RULE2 RULE3
            end
            // Computed flags override any written value
            if (alu.z_upd) begin
                d.status[csr_pkg::CSR_ST_Z] = alu.z; // RULE1 RULE11
            end
            if (alu.dc_upd) begin
                d.status[csr_pkg::CSR_ST_DC] = alu.dc; // RULE1 RULE12
            end
            if (alu.c_upd) begin
                d.status[csr_pkg::CSR_ST_C] = alu.c; // RULE1 RULE13
            end
        end
        // Set events win over the timeout clear
        if (watchdog_timeout) begin
            d.status[csr_pkg::CSR_ST_TO] = 1'b0; // RULE9
        end
        if (watchdog_kick_op || sleep_op) begin
            d.status[csr_pkg::CSR_ST_TO] = 1'b1; // RULE8
        end
        if (sleep_op) begin
            d.status[csr_pkg::CSR_ST_PD] = 1'b0; // RULE10
        end
        if (watchdog_kick_op) begin
            d.status[csr_pkg::CSR_ST_PD] = 1'b1; // RULE10
        end
        d.dir_addr = {q.status[csr_pkg::CSR_ST_RP1:csr_pkg::CSR_ST_RP0], core_req.dir_addr}; // RULE7
        d.ind_addr = {q.status[csr_pkg::CSR_ST_IRP], core_req.fsr}; // RULE6
        d.pullup_en = q.option[csr_pkg::CSR_OP_PUDIS] ? 8'h00 : q.pullup_mask; // RULE16
        d.ext_s1 = ext_irq_pin;
        d.ext_s2 = q.ext_s1;
        d.ext_p  = q.ext_s2;
        d.tck_s1 = tick_input_pin;
        d.tck_s2 = q.tck_s1;
        d.tck_p  = q.tck_s2;
        if (q.option[csr_pkg::CSR_OP_IEDGE]) begin // RULE17
            d.ext_irq = q.ext_s2 & ~q.ext_p;
        end else begin
            d.ext_irq = ~q.ext_s2 & q.ext_p;
        end
        // Shared prescaler follows its owner
        if (q.option[csr_pkg::CSR_OP_OWNER]) begin // RULE20
            if (wdt_base_tick) begin
                d.prescale = q.prescale + 8'h01;
            end
            d.wdt_tick = wdt_base_tick && ((q.prescale & csr_mask(ps)) == csr_mask(ps)); // RULE21
        end else begin
            if (src_ev) begin
                d.prescale = q.prescale + 8'h01;
            end
            d.wdt_tick = wdt_base_tick;
        end
        d.tick_ovf = tick_inc && (q.tick_count == 8'hFF);
        if (tick_inc) begin
            d.tick_count = q.tick_count + 8'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= csr_pkg::CSR_STATE_RST; // RULE8 RULE10 RULE15
        end else begin
            q <= d;
        end
    end

    assign prdata        = q.prdata;
    assign pready        = q.pready;
    assign pslverr       = q.pslverr;
    assign status_flags  = q.status;
    assign option_bits   = q.option;
    assign alu_result    = q.alu_result;
    assign dir_addr      = q.dir_addr;
    assign ind_addr      = q.ind_addr;
    assign pullup_en     = q.pullup_en;
    assign ext_irq_event = q.ext_irq;
    assign tick_overflow = q.tick_ovf;
    assign wdt_tick      = q.wdt_tick;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic quiet;
    assign quiet = !watchdog_kick_op && !sleep_op && !watchdog_timeout;

    flag_override_a: assert property ( // RULE1
        core_req.op == csr_pkg::CSR_ADD && core_req.dest_status
        |=> status_flags[2:0] == {$past(alu.z), $past(alu.dc), $past(alu.c)})
        else $error("status flags not from add result");
    ro_flags_a: assert property ( // RULE2
        psel && penable && pready && pwrite && sel == 3'h0 && quiet
        |=> $stable(status_flags[4:3]))
        else $error("read-only status flags changed by write");
    clear_status_a: assert property ( // RULE3
        core_req.op == csr_pkg::CSR_CLEAR && core_req.dest_status && quiet
        |=> status_flags == {3'b000, $past(status_flags[4:3]), 1'b1, $past(status_flags[1:0])})
        else $error("file clear of status wrong");
    sub_borrow_a: assert property ( // RULE5
        core_req.op == csr_pkg::CSR_SUB && core_req.acc > core_req.file && !core_req.dest_status
        |=> !status_flags[csr_pkg::CSR_ST_C])
        else $error("borrow not shown as carry low");
    ind_bank_a: assert property ( // RULE6
        ##1 ind_addr == {$past(status_flags[7]), $past(core_req.fsr)})
        else $error("indirect address bank wrong");
    dir_bank_a: assert property ( // RULE7
        ##1 dir_addr == {$past(status_flags[6:5]), $past(core_req.dir_addr)})
        else $error("direct address bank wrong");
    sleep_flags_a: assert property ( // RULE8
        sleep_op && !watchdog_kick_op |=> status_flags[4:3] == 2'b10)
        else $error("sleep flags wrong");
    timeout_a: assert property ( // RULE9
        watchdog_timeout && !watchdog_kick_op && !sleep_op |=> !status_flags[4])
        else $error("timeout did not clear expiry flag");
    kick_flags_a: assert property ( // RULE10
        watchdog_kick_op |=> status_flags[4:3] == 2'b11)
        else $error("kick flags wrong");
    option_write_a: assert property ( // RULE15
        psel && penable && pready && pwrite && sel == 3'h1
        && (core_req.op == csr_pkg::CSR_NONE || !core_req.dest_option)
        |=> option_bits == $past(pwdata[7:0]) ##2 pullup_en[0] != option_bits[7] || !pullup_en[0])
        else $error("option write lost");
    pullup_gate_a: assert property ( // RULE16
        ##1 pullup_en == ($past(option_bits[7]) ? 8'h00 : $past(q.pullup_mask)))
        else $error("pull-up gating wrong");
    wdt_div1_a: assert property ( // RULE20
        option_bits[3] && option_bits[2:0] == 3'h0 && wdt_base_tick |=> wdt_tick)
        else $error("watchdog 1:1 tick missing");
    tick_div2_a: assert property ( // RULE21
        !option_bits[5] && !option_bits[3] && option_bits[2:0] == 3'h0
        && instr_cycle && q.prescale[0] && q.tick_count != 8'hFF
        |=> q.tick_count == $past(q.tick_count) + 8'h01)
        else $error("tick 1:2 divide wrong");

    cover_sub_c: cover property (core_req.op == csr_pkg::CSR_SUB ##1 status_flags[0]);
    cover_ovf_c: cover property (tick_overflow);
    cover_irq_c: cover property (ext_irq_event);
    cover_rd_c: cover property (psel && penable && pready && !pwrite && !pslverr);
endmodule // csr_core_status_option_regs

// ---- csr_core_status_option_regs_test.sv ----
// Self-checking bench for the core status/option register bank.
// Assumes csr_pkg is compiled first; drives APB and core strobes itself.
`timescale 1ns/1ps
module csr_core_status_option_regs_test;
    logic                      pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0]               paddr;
    logic [31:0]               pwdata, prdata, r;
    csr_pkg::csr_core_req_type req;
    logic                      kick, sleep, tmo, icyc, ext_pin, e, ev, tpin, wtick, wt, ov;
    logic [7:0]                status_flags, option_bits, alu_result, pullup_en, st, v, t0;
    logic [8:0]                dir_addr, ind_addr;
    logic [15:0]               ex;
    int                        fails, total_checks, n;
    integer                    seed;

    csr_core_status_option_regs csr_core_status_option_regs_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .core_req(req), .watchdog_kick_op(kick), .sleep_op(sleep), .watchdog_timeout(tmo),
        .instr_cycle(icyc), .wdt_base_tick(wtick), .ext_irq_pin(ext_pin), .tick_input_pin(tpin),
        .status_flags(status_flags), .option_bits(option_bits), .alu_result(alu_result),
        .dir_addr(dir_addr), .ind_addr(ind_addr), .pullup_en(pullup_en),
        .ext_irq_event(ev), .tick_overflow(ov), .wdt_tick(wt));

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    task automatic end_of_test;
        $display("checks=%0d fails=%0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
        total_checks++;
        if (s !== x) begin
            fails++;
            $display("[ERR] %s expected %0h seen %0h", nm, x, s);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        if (pready !== 1'b1) begin
            fails++;
            end_of_test();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Returns {result, new status}; any flag-affecting op blocks the write of all three flags
    function automatic logic [15:0] model(csr_pkg::csr_op_type op, logic [7:0] a, logic [7:0] f,
                                          logic [7:0] s, logic d);
        logic [8:0] t;
        logic [4:0] h;
        logic [7:0] q;
        logic [2:0] fl, m;
        fl = s[2:0];
        m = 3'h7;
        q = 8'h00;
        case (op)
            csr_pkg::CSR_ADD: begin
                t = {1'b0, a} + {1'b0, f};
                h = {1'b0, a[3:0]} + {1'b0, f[3:0]};
                q = t[7:0]; fl[1:0] = {h[4], t[8]};
            end
            csr_pkg::CSR_SUB: begin
                t = {1'b0, f} + {1'b0, ~a} + 9'h001;
                h = {1'b0, f[3:0]} + {1'b0, ~a[3:0]} + 5'h01;
                q = t[7:0]; fl[1:0] = {h[4], t[8]};
            end
            csr_pkg::CSR_AND: begin q = a & f; m = 3'h4; end
            csr_pkg::CSR_IOR: begin q = a | f; m = 3'h4; end
            csr_pkg::CSR_XOR: begin q = a ^ f; m = 3'h4; end
            csr_pkg::CSR_ROTL: begin q = {f[6:0], s[0]}; fl[0] = f[7]; m = 3'h1; end
            csr_pkg::CSR_ROTR: begin q = {s[0], f[7:1]}; fl[0] = f[0]; m = 3'h1; end
            csr_pkg::CSR_MOVE: begin q = a; m = 3'h0; end
            default: m = 3'h4;
        endcase
        if (m[2])
            fl[2] = (q == 8'h00);
        if (d) begin
            s[7:5] = q[7:5];
            if (m == 3'h0)
                s[2:0] = q[2:0];
        end
        s[2:0] = (fl & m) | (s[2:0] & ~m);
        return {q, s};
    endfunction

    task automatic core_op(input csr_pkg::csr_op_type op, input logic [7:0] a, input logic [7:0] f,
                           input logic d);
        ex = model(op, a, f, st, d);
        @(posedge pclk);
        req.op <= op; req.acc <= a; req.file <= f; req.dest_status <= d;
        req.dir_addr <= 7'($random(seed)); req.fsr <= 8'($random(seed));
        @(posedge pclk);
        req.op <= csr_pkg::CSR_NONE;
        #1;
        st = ex[7:0];
        chk("status", 32'(status_flags), 32'(st));
        chk("alu", 32'(alu_result), 32'(ex[15:8]));
        @(posedge pclk);
        #1;
        chk("dir", 32'(dir_addr), 32'({st[6:5], req.dir_addr}));
        chk("ind", 32'(ind_addr), 32'({st[7], req.fsr}));
    endtask

    task automatic flag_ev(input logic [2:0] k, input logic [1:0] x);
        @(posedge pclk);
        {kick, sleep, tmo} <= k;
        @(posedge pclk);
        {kick, sleep, tmo} <= 3'h0;
        #1;
        st[4:3] = x;
        chk("to_pd", 32'(status_flags[4:3]), 32'(x));
    endtask

    task automatic pin_to(input logic p, output int c);
        @(posedge pclk);
        ext_pin <= p;
        c = 0;
        repeat (8) begin
            @(posedge pclk);
            c += int'(ev === 1'b1);
        end
    endtask

    initial begin
        seed = 32'h49474fa5;
        fails = 0; total_checks = 0;
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
        pwdata = 32'h0; req = '0; kick = 1'b0; sleep = 1'b0; tmo = 1'b0; icyc = 1'b0;
        ext_pin = 1'b0; tpin = 1'b0; wtick = 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, csr_pkg::CSR_OFF_STATUS, 32'h0);
        chk("status_rst", r, 32'h18);
        apb(1'b0, csr_pkg::CSR_OFF_OPTION, 32'h0);
        chk("option_rst", r, 32'hFF);
        apb(1'b1, 12'h010, 32'hA5);
        chk("bad_err", 32'(e), 32'h1);
        apb(1'b0, 12'h010, 32'h0);
        chk("bad_rd", r, 32'h0);
        for (int i = 0; i < 4; i++) begin
            v = {i[0], 7'($random(seed))};
            t0 = 8'($random(seed));
            apb(1'b1, csr_pkg::CSR_OFF_OPTION, 32'(v));
            apb(1'b1, csr_pkg::CSR_OFF_PULLUP, 32'(t0));
            apb(1'b0, csr_pkg::CSR_OFF_OPTION, 32'h0);
            chk("option", r, 32'(v));
            chk("pullup", 32'(pullup_en), v[7] ? 32'h0 : 32'(t0));
        end
        v = 8'($random(seed));
        apb(1'b1, csr_pkg::CSR_OFF_STATUS, {24'h0, v ^ 8'h18});
        st = {v[7:5], 2'b11, v[2:0]};
        apb(1'b0, csr_pkg::CSR_OFF_STATUS, 32'h0);
        chk("status_wr", r, 32'(st));
        flag_ev(3'b001, 2'b01);
        flag_ev(3'b100, 2'b11);
        flag_ev(3'b001, 2'b01);
        flag_ev(3'b010, 2'b10);
        flag_ev(3'b110, 2'b11);
        flag_ev(3'b101, 2'b11);
        core_op(csr_pkg::CSR_MOVE, 8'hE7, 8'h00, 1'b1);
        core_op(csr_pkg::CSR_CLEAR, 8'h00, 8'h5A, 1'b1);
        core_op(csr_pkg::CSR_ADD, 8'h88, 8'h88, 1'b1);
        core_op(csr_pkg::CSR_ADD, 8'h01, 8'h0F, 1'b0);
        core_op(csr_pkg::CSR_SUB, 8'h3C, 8'h3C, 1'b1);
        core_op(csr_pkg::CSR_SUB, 8'h41, 8'h30, 1'b0);
        core_op(csr_pkg::CSR_ROTL, 8'h00, 8'h81, 1'b0);
        core_op(csr_pkg::CSR_ROTR, 8'h00, 8'h01, 1'b0);
        for (int i = 0; i < 60; i++)
            core_op(csr_pkg::csr_op_type'({$random(seed)} % 9 + 1), 8'($random(seed)),
                    8'($random(seed)), 1'($random(seed)));
        // Event count is a multiple of every ratio used, so prescaler phase cancels out
        for (int i = 0; i < 3; i++) begin
            v = (i == 0) ? 8'hCF : (i == 1) ? 8'hC0 : 8'hC2;
            apb(1'b1, csr_pkg::CSR_OFF_OPTION, 32'(v));
            // Start near the top so the count wraps and overflow is seen in the first two passes (1:8 pass counts only 2)
            apb(1'b1, csr_pkg::CSR_OFF_TICK, 32'hF8);
            apb(1'b0, csr_pkg::CSR_OFF_TICK, 32'h0);
            t0 = r[7:0];
            n = 0;
            repeat (16) begin
                @(posedge pclk) icyc <= 1'b1;
                n += int'(ov === 1'b1);
                @(posedge pclk) icyc <= 1'b0;
                n += int'(ov === 1'b1);
            end
            repeat (3) begin
                @(posedge pclk);
                n += int'(ov === 1'b1);
            end
            apb(1'b0, csr_pkg::CSR_OFF_TICK, 32'h0);
            chk("tick", 32'(8'(r[7:0] - t0)), (i == 0) ? 32'd16 : 32'd16 >> (v[2:0] + 1));
            chk("tick_ovf", 32'(n), (i == 2) ? 32'd0 : 32'd1);
        end
        // Pin source: three rises and two falls
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, csr_pkg::CSR_OFF_OPTION, {26'h0, 1'b1, i[0], 1'b1, 3'h0});
            @(posedge pclk) tpin <= 1'b0;
            repeat (4) @(posedge pclk);
            apb(1'b0, csr_pkg::CSR_OFF_TICK, 32'h0);
            t0 = r[7:0];
            for (int j = 0; j < 5; j++)
                repeat (4) @(posedge pclk) tpin <= !j[0];
            repeat (4) @(posedge pclk);
            apb(1'b0, csr_pkg::CSR_OFF_TICK, 32'h0);
            chk("tick_pin", 32'(8'(r[7:0] - t0)), i ? 32'd2 : 32'd3);
        end
        // Watchdog owns the prescaler; 16 base ticks at each ratio
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, csr_pkg::CSR_OFF_OPTION, 32'(8 + i));
            n = 0;
            for (int j = 0; j < 36; j++) begin
                @(posedge pclk);
                n += int'(wt === 1'b1);
                wtick <= (j < 32) && !j[0];
            end
            chk("wdt_tick", 32'(n), 32'd16 >> i);
        end
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, csr_pkg::CSR_OFF_OPTION, {25'h0, i[0], 6'h0F});
            pin_to(1'b1, n);
            chk("irq_rise", 32'(n), 32'(i));
            pin_to(1'b0, n);
            chk("irq_fall", 32'(n), 32'(1 - i));
        end
        end_of_test();
    end
endmodule // csr_core_status_option_regs_test
